// >>> hw/pivm_params.svh
// Constants for the peripheral interrupt vector map.
// Assumes it is included by the package and by the design files.
`ifndef PIVM_PARAMS_SVH
`define PIVM_PARAMS_SVH

`define PIVM_NUM_VECTORS      31
`define PIVM_FLAG_RESET       31'h0000_0000
// Vectors that own a source; reset entry and gaps stay zero
`define PIVM_VALID_MASK       31'h7F32_3FFE
`define PIVM_NMI_MASK         31'h0000_0002

`define PIVM_VEC_RESET        0
`define PIVM_VEC_SCAN_NMI     1
`define PIVM_VEC_SUPPLY       2
`define PIVM_VEC_PORT_A       3
`define PIVM_VEC_PORT_B       4
`define PIVM_VEC_PORT_C       5
`define PIVM_VEC_RT_COUNTER   6
`define PIVM_VEC_PERIODIC     7
`define PIVM_VEC_TA_OVF       8
`define PIVM_VEC_TA_HUNF      9
`define PIVM_VEC_TA_CMP0      10
`define PIVM_VEC_TA_CMP1      11
`define PIVM_VEC_TA_CMP2      12
`define PIVM_VEC_TIMER_B      13
`define PIVM_VEC_COMPARATOR   17
`define PIVM_VEC_CONV_RESULT  20
`define PIVM_VEC_CONV_WINDOW  21
`define PIVM_VEC_TW_TARGET    24
`define PIVM_VEC_TW_CTRL      25
`define PIVM_VEC_SERIAL_PERIPH 26
`define PIVM_VEC_SER_RX       27
`define PIVM_VEC_SER_TX_EMPTY 28
`define PIVM_VEC_SER_TX_DONE  29
`define PIVM_VEC_NVM_READY    30

`endif

// >>> hw/pivm_pkg.sv
// Types and helpers for the peripheral interrupt vector map.
// Assumes pivm_params.svh is on the include path.
`include "pivm_params.svh"

package pivm_pkg;

  typedef logic [`PIVM_NUM_VECTORS-1:0] pivm_vec_t;

  // One-hot word for a vector number
  function automatic pivm_vec_t pivm_bit(input int unsigned idx);
    pivm_vec_t one;
    one = pivm_vec_t'(1);
    return one << idx;
  endfunction : pivm_bit

endpackage : pivm_pkg

// >>> hw/pivm_flag_bank.sv
// Sticky flag bank, one flag per vector slot.
// Assumes set and clear are one-cycle pulses on clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "pivm_params.svh"

module pivm_flag_bank (
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire pivm_pkg::pivm_vec_t set_i,
  input  wire pivm_pkg::pivm_vec_t clear_i,
  output var  pivm_pkg::pivm_vec_t flag_o
);

  pivm_pkg::pivm_vec_t flag;
  pivm_pkg::pivm_vec_t next_flag;

  // Set wins over a clear in the same cycle; gaps never hold a flag
  always_comb begin
    next_flag = ((flag & ~clear_i) | set_i) & `PIVM_VALID_MASK;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag <= `PIVM_FLAG_RESET;
    end else begin
      flag <= next_flag;
    end
  end

  assign flag_o = flag;

endmodule : pivm_flag_bank
`default_nettype wire

// >>> hw/pivm_vector_map.sv
// Peripheral interrupt gathering and fixed vector mapping.
// Assumes all condition, enable and clear inputs are on clk_i.
//
// How it works
// - Each assigned vector slot belongs to one peripheral; a peripheral may own several.
// - A detected condition sets its flag whether or not it is enabled.
// - Each source has a software-written enable bit gating its request.
// - A request is raised only in the cycle after enable and flag were both set.
// - Requests are levels held until the flag is cleared.
// - Global interrupt enable must also be set for any request except vector 1.
// - Memory-scan checksum non-maskable interrupt uses vector 1.
// - Supply monitor vector 2; port A, B, C pin changes vectors 3-5.
// - Real-time counter overflow/compare uses vector 6.
// - Periodic tick inside the real-time counter uses vector 7.
// - Timer A: overflow/low underflow 8, high underflow 9, compares 10-12.
// - Timer B combined interrupt uses vector 13.
// - Analog comparator interrupt uses vector 17.
// - Converter result ready uses vector 20, window compare 21.
// - Two-wire target side uses vector 24, controller side 25.
// - Serial peripheral interface combined interrupt uses vector 26.
// - Serial port: receive 27, transmit empty 28, transmit done 29.
// - Nonvolatile memory data ready uses vector 30.
`timescale 1ns/1ps
`default_nettype none
`include "pivm_params.svh"

module pivm_vector_map (
  input  wire logic                clk_i,
  input  wire logic                reset_n_i,
  input  wire logic                global_irq_enable_i,
  input  wire logic                timer_a_split_mode_i,
  input  wire logic                scan_checksum_nmi_i,
  input  wire logic                supply_level_monitor_irq_i,
  input  wire logic                port_a_pin_irq_i,
  input  wire logic                port_b_pin_irq_i,
  input  wire logic                port_c_pin_irq_i,
  input  wire logic                rt_counter_irq_i,
  input  wire logic                periodic_tick_irq_i,
  input  wire logic                timer_a_overflow_irq_i,
  input  wire logic                timer_a_low_underflow_irq_i,
  input  wire logic                timer_a_high_underflow_irq_i,
  input  wire logic                timer_a_compare0_irq_i,
  input  wire logic                timer_a_compare1_irq_i,
  input  wire logic                timer_a_compare2_irq_i,
  input  wire logic                timer_a_low_compare0_irq_i,
  input  wire logic                timer_a_low_compare1_irq_i,
  input  wire logic                timer_a_low_compare2_irq_i,
  input  wire logic                timer_b_irq_i,
  input  wire logic                comparator_irq_i,
  input  wire logic                converter_result_ready_irq_i,
  input  wire logic                converter_window_irq_i,
  input  wire logic                two_wire_target_irq_i,
  input  wire logic                two_wire_controller_irq_i,
  input  wire logic                serial_periph_irq_i,
  input  wire logic                serial_rx_complete_irq_i,
  input  wire logic                serial_tx_empty_irq_i,
  input  wire logic                serial_tx_complete_irq_i,
  input  wire logic                nvm_data_ready_irq_i,
  input  wire pivm_pkg::pivm_vec_t source_enable_bit_i,
  input  wire pivm_pkg::pivm_vec_t flag_clear_i,
  output var  pivm_pkg::pivm_vec_t irq_flag_reg_o,
  output var  pivm_pkg::pivm_vec_t irq_request_o
);

  pivm_pkg::pivm_vec_t set_vec;
  pivm_pkg::pivm_vec_t irq_request;
  pivm_pkg::pivm_vec_t next_irq_request;
  pivm_pkg::pivm_vec_t gate;

  // Condition to vector slot; split mode swaps the timer A sources
  always_comb begin
    set_vec = '0;
    if (scan_checksum_nmi_i) begin
      set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_SCAN_NMI);
    end
    if (supply_level_monitor_irq_i) begin
      set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_SUPPLY);
    end
    if (port_a_pin_irq_i) begin
      set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_PORT_A);
    end
    if (port_b_pin_irq_i) begin
      set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_PORT_B);
    end
    if (port_c_pin_irq_i) begin
      set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_PORT_C);
    end
    if (rt_counter_irq_i) begin
      set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_RT_COUNTER);
    end
    if (periodic_tick_irq_i) begin
      set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_PERIODIC);
    end
    if (timer_a_split_mode_i) begin
      if (timer_a_low_underflow_irq_i) begin
        set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_TA_OVF);
      end
      if (timer_a_high_underflow_irq_i) begin
        set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_TA_HUNF);
      end
      if (timer_a_low_compare0_irq_i) begin
        set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_TA_CMP0);
      end
      if (timer_a_low_compare1_irq_i) begin
        set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_TA_CMP1);
      end
      if (timer_a_low_compare2_irq_i) begin
        set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_TA_CMP2);
      end
    end else begin
      // High underflow only exists in split mode
      if (timer_a_overflow_irq_i) begin
        set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_TA_OVF);
      end
      if (timer_a_compare0_irq_i) begin
        set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_TA_CMP0);
      end
      if (timer_a_compare1_irq_i) begin
        set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_TA_CMP1);
      end
      if (timer_a_compare2_irq_i) begin
        set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_TA_CMP2);
      end
    end
    if (timer_b_irq_i) begin
      set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_TIMER_B);
    end
    if (comparator_irq_i) begin
      set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_COMPARATOR);
    end
    if (converter_result_ready_irq_i) begin
      set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_CONV_RESULT);
    end
    if (converter_window_irq_i) begin
      set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_CONV_WINDOW);
    end
    if (two_wire_target_irq_i) begin
      set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_TW_TARGET);
    end
    if (two_wire_controller_irq_i) begin
      set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_TW_CTRL);
    end
    if (serial_periph_irq_i) begin
      set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_SERIAL_PERIPH);
    end
    if (serial_rx_complete_irq_i) begin
      set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_SER_RX);
    end
    if (serial_tx_empty_irq_i) begin
      set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_SER_TX_EMPTY);
    end
    if (serial_tx_complete_irq_i) begin
      set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_SER_TX_DONE);
    end
    if (nvm_data_ready_irq_i) begin
      set_vec |= pivm_pkg::pivm_bit(`PIVM_VEC_NVM_READY);
    end
  end

  // One flag per slot, so no slot is shared by two peripherals
  pivm_flag_bank u_flags (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .set_i     (set_vec),
    .clear_i   (flag_clear_i),
    .flag_o    (irq_flag_reg_o)
  );

  // Non-maskable slot ignores the global enable, by its nature
  always_comb begin
    gate = global_irq_enable_i ? `PIVM_VALID_MASK : `PIVM_NMI_MASK;
    next_irq_request = irq_flag_reg_o & source_enable_bit_i
                     & gate & `PIVM_VALID_MASK;
  end

  // Level output follows the flag, not the condition
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_request <= `PIVM_FLAG_RESET;
    end else begin
      irq_request <= next_irq_request;
    end
  end

  assign irq_request_o = irq_request;

  chk_reset_slot_idle: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !irq_request_o[`PIVM_VEC_RESET] && !irq_flag_reg_o[`PIVM_VEC_RESET])
    else $error("reset vector requested");

  chk_gap_slots_idle: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (irq_request_o & ~`PIVM_VALID_MASK) == '0)
    else $error("unassigned vector requested");

  chk_request_needs_both: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    ##1 (irq_request_o
         & ~$past(irq_flag_reg_o & source_enable_bit_i)) == '0)
    else $error("request without flag and enable");

  chk_global_gate: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !global_irq_enable_i |=> (irq_request_o & ~`PIVM_NMI_MASK) == '0)
    else $error("request while globally disabled");

  chk_flag_ignores_enable: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    supply_level_monitor_irq_i && !source_enable_bit_i[`PIVM_VEC_SUPPLY]
    |=> irq_flag_reg_o[`PIVM_VEC_SUPPLY])
    else $error("disabled source did not set flag");

  chk_level_holds: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    irq_flag_reg_o[`PIVM_VEC_SUPPLY] && !supply_level_monitor_irq_i
    && !flag_clear_i[`PIVM_VEC_SUPPLY]
    && source_enable_bit_i[`PIVM_VEC_SUPPLY] && global_irq_enable_i
    |=> irq_request_o[`PIVM_VEC_SUPPLY] ##0 irq_flag_reg_o[`PIVM_VEC_SUPPLY])
    else $error("request dropped without clear");

  chk_clear_drops: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    flag_clear_i[`PIVM_VEC_PORT_A] && !port_a_pin_irq_i
    |=> !irq_flag_reg_o[`PIVM_VEC_PORT_A] ##1 !irq_request_o[`PIVM_VEC_PORT_A])
    else $error("clear did not withdraw request");

  chk_set_wins: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    port_b_pin_irq_i && flag_clear_i[`PIVM_VEC_PORT_B]
    |=> irq_flag_reg_o[`PIVM_VEC_PORT_B])
    else $error("set lost to clear");

  chk_nmi_slot: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    scan_checksum_nmi_i ##1 source_enable_bit_i[`PIVM_VEC_SCAN_NMI]
    |=> irq_request_o[`PIVM_VEC_SCAN_NMI])
    else $error("checksum nmi not on vector 1");

  chk_split_slot: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    timer_a_split_mode_i && timer_a_low_underflow_irq_i
    |=> irq_flag_reg_o[`PIVM_VEC_TA_OVF])
    else $error("low underflow not on vector 8");

  chk_port_c_slot: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    port_c_pin_irq_i |=> irq_flag_reg_o[`PIVM_VEC_PORT_C])
    else $error("port c not on vector 5");

endmodule : pivm_vector_map
`default_nettype wire

// >>> sim/pivm_core_model.sv
// Core-side model: services requests by pulsing the matching clear.
// Assumes requests are registered on clk_i; clears change at falling edge.
`timescale 1ns/1ps
`default_nettype none

module pivm_core_model (
  input  wire logic                clk_i,
  input  wire logic                reset_n_i,
  input  wire logic                global_irq_enable_i,
  input  wire logic [3:0]          delay_i,
  input  wire pivm_pkg::pivm_vec_t irq_request_i,
  output var  pivm_pkg::pivm_vec_t flag_clear_o
);
  logic [3:0]          wait_cnt;
  pivm_pkg::pivm_vec_t seen;
  int                  pick;

  // Only gated requests are taken; vector 1 bypasses the gate
  assign seen = irq_request_i &
                (global_irq_enable_i ? '1 : 31'h0000_0002);

  always @(negedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_clear_o <= '0;
      wait_cnt     <= '0;
    end else begin
      flag_clear_o <= '0;
      pick = -1;
      for (int n = 30; n >= 0; n--) begin
        if (seen[n] === 1'b1) pick = n;
      end
      if (wait_cnt != 0) begin
        wait_cnt <= wait_cnt - 1'b1;
      end else if (pick >= 0) begin
        // Lowest vector first; slow service stresses held levels
        flag_clear_o[pick] <= 1'b1;
        wait_cnt           <= delay_i;
      end
    end
  end
endmodule : pivm_core_model

`default_nettype wire

// >>> sim/peripheral_irq_vector_map_tb.sv
// Self-checking bench for the vector map with a cycle reference model.
// Assumes pivm_pkg and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none

module peripheral_irq_vector_map_tb;
  logic                clk_i;
  logic                reset_n_i;
  logic                glob;
  logic                split;
  logic [26:0]         cond;
  logic [3:0]          delay;
  pivm_pkg::pivm_vec_t en;
  pivm_pkg::pivm_vec_t rnd_clr;
  pivm_pkg::pivm_vec_t model_clr;
  pivm_pkg::pivm_vec_t clr;
  pivm_pkg::pivm_vec_t flag;
  pivm_pkg::pivm_vec_t req;
  pivm_pkg::pivm_vec_t ef;
  pivm_pkg::pivm_vec_t er;
  pivm_pkg::pivm_vec_t set_w;
  int                  n_errors;
  int                  check_count;
  logic [31:0]         seed;
  int unsigned vmap [27] = '{1, 2, 3, 4, 5, 6, 7, 8, 8, 9, 10, 11, 12, 10,
                             11, 12, 13, 17, 20, 21, 24, 25, 26, 27, 28, 29, 30};

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  // Timer A sources follow the split-mode selection
  function automatic pivm_pkg::pivm_vec_t exp_set(input logic [26:0] c,
                                                  input logic sp);
    pivm_pkg::pivm_vec_t r;
    logic                act;
    r = '0;
    for (int i = 0; i < 27; i++) begin
      act = 1'b1;
      if (i == 7 || (i >= 10 && i <= 12)) act = !sp;
      if (i == 8 || i == 9 || (i >= 13 && i <= 15)) act = sp;
      if (c[i] && act) r[vmap[i]] = 1'b1;
    end
    return r;
  endfunction : exp_set

  assign clr   = model_clr | rnd_clr;
  assign set_w = exp_set(cond, split);

  pivm_vector_map pivm_vector_map_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .global_irq_enable_i(glob),
    .timer_a_split_mode_i(split), .scan_checksum_nmi_i(cond[0]),
    .supply_level_monitor_irq_i(cond[1]), .port_a_pin_irq_i(cond[2]),
    .port_b_pin_irq_i(cond[3]), .port_c_pin_irq_i(cond[4]),
    .rt_counter_irq_i(cond[5]), .periodic_tick_irq_i(cond[6]),
    .timer_a_overflow_irq_i(cond[7]), .timer_a_low_underflow_irq_i(cond[8]),
    .timer_a_high_underflow_irq_i(cond[9]),
    .timer_a_compare0_irq_i(cond[10]), .timer_a_compare1_irq_i(cond[11]),
    .timer_a_compare2_irq_i(cond[12]),
    .timer_a_low_compare0_irq_i(cond[13]),
    .timer_a_low_compare1_irq_i(cond[14]),
    .timer_a_low_compare2_irq_i(cond[15]), .timer_b_irq_i(cond[16]),
    .comparator_irq_i(cond[17]), .converter_result_ready_irq_i(cond[18]),
    .converter_window_irq_i(cond[19]), .two_wire_target_irq_i(cond[20]),
    .two_wire_controller_irq_i(cond[21]), .serial_periph_irq_i(cond[22]),
    .serial_rx_complete_irq_i(cond[23]), .serial_tx_empty_irq_i(cond[24]),
    .serial_tx_complete_irq_i(cond[25]), .nvm_data_ready_irq_i(cond[26]),
    .source_enable_bit_i(en), .flag_clear_i(clr),
    .irq_flag_reg_o(flag), .irq_request_o(req));

  pivm_core_model pivm_core_model_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .global_irq_enable_i(glob),
    .delay_i(delay), .irq_request_i(req), .flag_clear_o(model_clr));

  // Reference: set wins over clear, request one edge behind the flag
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ef <= '0;
      er <= '0;
    end else begin
      ef <= (ef & ~clr) | set_w;
      er <= ef & en & (glob ? '1 : 31'h0000_0002);
    end
  end

  task automatic check(input pivm_pkg::pivm_vec_t seen,
                       input pivm_pkg::pivm_vec_t exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s %h, wanted %h", $time, what, seen, exp);
    end
  endtask : check

  always @(negedge clk_i) begin
    check(flag, ef, "flags");
    check(flag & 31'h00CD_C001, '0, "idle flags");
    check(req, er, "requests");
  end

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Hang guard well beyond the planned run
  initial begin
    #400000;
    n_errors++;
    test_done();
  end

  initial begin
    reset_n_i = 1'b0;
    glob = 1'b1;
    split = 1'b0;
    cond = '0;
    en = '1;
    rnd_clr = '0;
    delay = 4'h0;
    n_errors = 0;
    check_count = 0;
    seed = 32'h0001_71CA;
    repeat (6) @(negedge clk_i);
    reset_n_i = 1'b1;
    // Every source alone, both timer A modes, prompt then slow service
    for (int sp = 0; sp < 2; sp++) begin
      for (int i = 0; i < 27; i++) begin
        @(negedge clk_i);
        split = sp[0];
        delay = sp[0] ? 4'h6 : 4'h0;
        cond = 27'h1 << i;
        @(negedge clk_i);
        cond = '0;
        repeat (10) @(negedge clk_i);
      end
    end
    $display("test mapping done");
    // Random traffic: sparse conditions, enables, gate, clears, mode
    for (int k = 0; k < 3000; k++) begin
      @(negedge clk_i);
      seed = xs(seed);
      cond = seed[26:0] & xs(seed)[26:0] & xs(xs(seed))[26:0];
      seed = xs(seed);
      if (seed[3:0] == 4'h0) en = seed[30:0];
      if (seed[7:4] == 4'h0) glob = ~glob;
      if (seed[11:6] == 6'h00) split = ~split;
      rnd_clr = (seed[15:12] == 4'h0) ? xs(seed)[30:0] : '0;
      delay = seed[19:16];
      if (k == 1500) begin
        reset_n_i = 1'b0;
        @(negedge clk_i);
        reset_n_i = 1'b1;
      end
    end
    $display("test random done");
    test_done();
  end
endmodule : peripheral_irq_vector_map_tb

`default_nettype wire
